/* core/fcl_pkg.sv */
package fcl_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Timing, from the 40 MHz core clock
	localparam int CLK_MHZ = 40;
	localparam int RELEASE_DELAY_NS = 3000;
	localparam int PROG_TIME_NS = 20000;
	localparam int ERASE_TIME_NS = 80000;
	localparam int REL_CYC = (RELEASE_DELAY_NS * CLK_MHZ + 999) / 1000;
	localparam int PROG_CYC = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int ERASE_CYC = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam logic [11:0] REL_CYC_W = 12'(REL_CYC);
	localparam logic [11:0] PROG_CYC_W = 12'(PROG_CYC);
	localparam logic [11:0] ERASE_CYC_W = 12'(ERASE_CYC);
	localparam logic [2:0] DUMMY_LAST = 3'h7;

	////////////////////////////////////////////////////////////////////////////////
	// Command codes
	localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;
	localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
	localparam logic [7:0] PARAM_ERASE_CMD = 8'h20;
	localparam logic [7:0] SECTOR_ERASE_CMD = 8'hD8;
	localparam logic [7:0] BULK_ERASE_CMD = 8'h60;
	localparam logic [7:0] BULK_ERASE_ALT_CMD = 8'hC7;
	localparam logic [7:0] RESET_ENABLE_CMD = 8'h66;
	localparam logic [7:0] RESET_CMD = 8'h99;
	localparam logic [7:0] LEGACY_RESET_CMD = 8'hF0;
	localparam logic [7:0] MODE_BIT_RESET_CMD = 8'hFF;
	localparam logic [7:0] DEEP_SLEEP_ENTRY_CMD = 8'hB9;
	localparam logic [7:0] DEEP_SLEEP_RELEASE_CMD = 8'hAB;
	localparam logic [7:0] IDENTIFICATION_READ_CMD = 8'h9F;
	localparam logic [7:0] QUAD_IDENTIFICATION_READ_CMD = 8'hAF;
	localparam logic [7:0] PARAMETER_TABLE_READ_CMD = 8'h5A;

	////////////////////////////////////////////////////////////////////////////////
	// Register map and fields
	localparam logic [7:0] REG_STATUS_OFS = 8'h00;
	localparam logic [7:0] REG_CONFIG_OFS = 8'h04;
	localparam logic [7:0] REG_LOCK_OFS = 8'h08;
	localparam logic [7:0] REG_STATE_OFS = 8'h0C;
	localparam int QUAD_BIT = 6;
	localparam int PAGE512_BIT = 4;
	localparam int CONT_BIT = 1;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] LOCK_RST = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Array model and identity bytes (identity values are arbitrary)
	localparam int MEM_BYTES = 64;
	localparam int MEM_AW = 6;
	localparam int SECTOR_AW = 4;
	localparam logic [7:0] ID_MFR = 8'hA5;
	localparam logic [7:0] ID_DEV0 = 8'h3C;
	localparam logic [7:0] ID_DEV1 = 8'h19;
	localparam logic [7:0] ID_EXT = 8'h4D;

	typedef enum logic [2:0] {PH_OPCODE, PH_ADDR, PH_DUMMY, PH_DATA_IN, PH_DATA_OUT, PH_IGNORE} fcl_phase_e;

	typedef struct packed {
		logic cs_b;
		logic sck;
		logic [3:0] io;
	} fcl_pins_s;

	typedef struct packed {
		logic en;
		logic [7:0] addr;
		logic [31:0] data;
	} fcl_wr_s;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] config2;
		logic [7:0] locks;
		logic [7:0] state;
	} fcl_rd_s;

endpackage : fcl_pkg

/* core/fcl_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module fcl_sync
	import fcl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire fcl_pins_s pins_in,
	output fcl_pins_s pins_out
);

	fcl_pins_s meta;

	// Only the second stage is visible to the rest of the block
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			meta <= '{cs_b: 1'b1, sck: 1'b0, io: 4'h0};
			pins_out <= '{cs_b: 1'b1, sck: 1'b0, io: 4'h0};
		end else begin
			meta <= pins_in;
			pins_out <= meta;
		end
	end

endmodule : fcl_sync
`default_nettype wire

/* core/fcl_ahb.sv */
`timescale 1ns/1ps
`default_nettype none
module fcl_ahb
	import fcl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire fcl_rd_s rd,
	output fcl_wr_s wr
);

	logic wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr;
	logic [31:0] next_hrdata;

	function automatic logic [31:0] rd_mux(input logic [31:0] a, input fcl_rd_s r);
		if (a[31:8] != 24'h000000) begin
			rd_mux = 32'h00000000;
		end else begin
			case (a[7:0])
				REG_STATUS_OFS: rd_mux = {24'h000000, r.status};
				REG_CONFIG_OFS: rd_mux = {24'h000000, r.config2};
				REG_LOCK_OFS: rd_mux = {24'h000000, r.locks};
				REG_STATE_OFS: rd_mux = {24'h000000, r.state};
				default: rd_mux = 32'h00000000;
			endcase
		end
	endfunction : rd_mux

	// Zero wait states: read data is fetched at the address phase edge
	always_comb begin
		next_wr_pend = 1'b0;
		next_wr_addr = wr_addr;
		next_hrdata = hrdata;
		if (hsel && hready && htrans[1]) begin
			if (hwrite) begin
				next_wr_pend = (haddr[31:8] == 24'h000000);
				next_wr_addr = haddr[7:0];
			end else begin
				next_hrdata = rd_mux(haddr, rd);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign wr = '{en: wr_pend, addr: wr_addr, data: hwdata};

endmodule : fcl_ahb
`default_nettype wire

/* core/fcl_flash_cmd.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Page program takes one byte up to a 256 or 512 byte page.
// - Programming only clears bits; returning a bit to one needs an erase.
// - Sector and bulk erase set every addressed bit to one.
// - Software reset equals hardware reset except lock bits and array contents are kept.
// - A dedicated command leaves continuous read mode.
// - Deep sleep entry accepted only while no operation is in progress.
// - In deep sleep only release is heard; standby follows after the release delay.
// - Reserved opcodes are accepted and do nothing.
// - Identification read during program, erase or write is ignored.
// - Identification read returns maker, two device, extended and table bytes.
// - Host may end any read by raising chip select; data past table undefined.
// - In quad mode identification read uses all four lines both ways.
// - Quad identification read is heard only when quad mode bit is set.
// - Parameter read: opcode, 24-bit address, eight dummy cycles, then MSb-first data.
// - The 24-bit address selects the first parameter byte returned.
// - In quad mode parameter read uses all four lines both ways.
module fcl_flash_cmd
	import fcl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic cs_b,
	input wire logic sck,
	input wire logic [3:0] io_in,
	output logic [3:0] io_out,
	output logic [3:0] io_oe,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output wire logic hreadyout,
	output wire logic hresp,
	output wire logic [31:0] hrdata
);

	fcl_pins_s pins_s;
	fcl_wr_s wr;
	fcl_rd_s rd;
	fcl_phase_e phase, next_phase;
	logic sck_q, cs_q, rise, fall, cs_rise, quad, byte_done, op_fire, sw_reset, prog_we, erase_fire;
	logic [7:0] opcode, next_opcode, shreg, next_shreg, nb, tx, next_tx, ob;
	logic [3:0] bitcnt, next_bitcnt, step, cnt_nx, next_io_out, next_io_oe;
	logic [1:0] abytes, next_abytes;
	logic [2:0] dcnt, next_dcnt, tx_left, next_tx_left;
	logic [23:0] addr, next_addr, optr, next_optr;
	logic [7:0] mem [MEM_BYTES];
	logic [7:0] next_mem [MEM_BYTES];
	logic operation_in_progress_bit, next_wip, wel, next_wel, deep_sleep_entry_cmd, next_dpd, rel_pend, next_rel_pend, cont, next_cont;
	logic armed, next_armed, op_ok, next_op_ok, got_data, next_got_data;
	logic [11:0] busy, next_busy, rel_cnt, next_rel_cnt;
	logic [7:0] config2, next_config2, locks, next_locks;

	function automatic logic [23:0] page_next(input logic [23:0] a, input logic big);
		if (big) begin
			page_next = {a[23:9], 9'(a[8:0] + 9'h001)};
		end else begin
			page_next = {a[23:8], 8'(a[7:0] + 8'h01)};
		end
	endfunction : page_next

	function automatic logic [7:0] id_byte(input logic [23:0] p);
		case (p)
			24'h000000: id_byte = ID_MFR;
			24'h000001: id_byte = ID_DEV0;
			24'h000002: id_byte = ID_DEV1;
			24'h000003: id_byte = ID_EXT;
			24'h000004: id_byte = 8'h51;
			24'h000005: id_byte = 8'h52;
			24'h000006: id_byte = 8'h59;
			default: id_byte = 8'hFF;
		endcase
	endfunction : id_byte

	function automatic logic [7:0] sfdp_byte(input logic [23:0] p);
		case (p)
			24'h000000: sfdp_byte = 8'h53;
			24'h000001: sfdp_byte = 8'h46;
			24'h000002: sfdp_byte = 8'h44;
			24'h000003: sfdp_byte = 8'h50;
			24'h000004: sfdp_byte = 8'h06;
			24'h000005: sfdp_byte = 8'h01;
			default: sfdp_byte = 8'hFF;
		endcase
	endfunction : sfdp_byte

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchroniser and register bus

	fcl_sync u_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.pins_in('{cs_b: cs_b, sck: sck, io: io_in}),
		.pins_out(pins_s)
	);

	fcl_ahb u_ahb (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.rd(rd),
		.wr(wr)
	);

	assign rd = '{status: {6'h00, wel, operation_in_progress_bit}, config2: config2, locks: locks, state: {5'h00, rel_pend, cont, deep_sleep_entry_cmd}};

	////////////////////////////////////////////////////////////////////////////////
	// Serial edges and byte assembly

	assign quad = config2[QUAD_BIT];
	assign rise = pins_s.sck && !sck_q && !pins_s.cs_b;
	assign fall = !pins_s.sck && sck_q && !pins_s.cs_b;
	assign cs_rise = pins_s.cs_b && !cs_q;
	assign step = quad ? 4'h4 : 4'h1;
	assign cnt_nx = bitcnt + step;
	assign nb = quad ? {shreg[3:0], pins_s.io} : {shreg[6:0], pins_s.io[0]};
	assign byte_done = rise && (cnt_nx == 4'h8) && (phase == PH_OPCODE || phase == PH_ADDR || phase == PH_DATA_IN);

	////////////////////////////////////////////////////////////////////////////////
	// Command engine

	always_comb begin
		next_phase = phase;
		next_opcode = opcode;
		next_shreg = shreg;
		next_bitcnt = bitcnt;
		next_abytes = abytes;
		next_dcnt = dcnt;
		next_tx = tx;
		next_tx_left = tx_left;
		next_addr = addr;
		next_optr = optr;
		next_mem = mem;
		next_wip = operation_in_progress_bit;
		next_wel = wel;
		next_dpd = deep_sleep_entry_cmd;
		next_rel_pend = rel_pend;
		next_cont = cont;
		next_armed = armed;
		next_op_ok = op_ok;
		next_got_data = got_data;
		next_busy = busy;
		next_rel_cnt = rel_cnt;
		next_config2 = config2;
		next_locks = locks;
		next_io_out = io_out;
		next_io_oe = io_oe;
		ob = tx;
		op_fire = 1'b0;
		sw_reset = 1'b0;
		prog_we = 1'b0;
		erase_fire = 1'b0;
		if (operation_in_progress_bit) begin
			next_busy = busy - 12'h001;
			if (busy == 12'h001) begin
				next_wip = 1'b0;
			end
		end
		if (rel_pend) begin
			next_rel_cnt = rel_cnt - 12'h001;
			if (rel_cnt == 12'h001) begin
				next_rel_pend = 1'b0;
				next_dpd = 1'b0;
			end
		end
		if (wr.en) begin
			case (wr.addr)
				REG_CONFIG_OFS: next_config2 = wr.data[7:0];
				// Lock bits can only be set; only a hardware reset clears them
				REG_LOCK_OFS: next_locks = locks | wr.data[7:0];
				REG_STATE_OFS: next_cont = cont | wr.data[CONT_BIT];
				default: ;
			endcase
		end
		if (rise) begin
			next_shreg = nb;
			next_bitcnt = (cnt_nx == 4'h8) ? 4'h0 : cnt_nx;
		end
		if (cs_rise) begin
			next_phase = PH_OPCODE;
			next_bitcnt = 4'h0;
			next_abytes = 2'h0;
			next_tx_left = 3'h0;
			next_io_oe = 4'h0;
			next_op_ok = 1'b0;
			next_got_data = 1'b0;
			if (op_ok && (opcode != PAGE_PROGRAM_CMD || got_data)) begin
				next_wip = 1'b1;
				next_wel = 1'b0;
				next_busy = (opcode == PAGE_PROGRAM_CMD) ? PROG_CYC_W : ERASE_CYC_W;
				if (opcode != PAGE_PROGRAM_CMD) begin
					erase_fire = 1'b1;
					for (int i = 0; i < MEM_BYTES; i++) begin
						if (opcode == BULK_ERASE_CMD || opcode == BULK_ERASE_ALT_CMD ||
						    2'(i >> SECTOR_AW) == addr[MEM_AW-1:SECTOR_AW]) begin
							next_mem[i] = 8'hFF;
						end
					end
				end
			end
		end else if (byte_done && phase == PH_OPCODE) begin
			op_fire = 1'b1;
			next_opcode = nb;
			next_phase = PH_IGNORE;
			next_armed = 1'b0;
			next_optr = 24'h000000;
			if (deep_sleep_entry_cmd) begin
				if (nb == DEEP_SLEEP_RELEASE_CMD && !rel_pend) begin
					next_rel_pend = 1'b1;
					next_rel_cnt = REL_CYC_W;
				end
			end else if (cont) begin
				next_cont = (nb != MODE_BIT_RESET_CMD);
			end else begin
				case (nb)
					WRITE_ENABLE_CMD: next_wel = wel | !operation_in_progress_bit;
					WRITE_DISABLE_CMD: next_wel = wel & operation_in_progress_bit;
					PAGE_PROGRAM_CMD, PARAM_ERASE_CMD, SECTOR_ERASE_CMD: begin
						if (!operation_in_progress_bit && wel) begin
							next_phase = PH_ADDR;
						end
					end
					BULK_ERASE_CMD, BULK_ERASE_ALT_CMD: next_op_ok = !operation_in_progress_bit && wel;
					RESET_ENABLE_CMD: next_armed = 1'b1;
					RESET_CMD: sw_reset = armed;
					LEGACY_RESET_CMD: sw_reset = 1'b1;
					MODE_BIT_RESET_CMD: next_cont = 1'b0;
					DEEP_SLEEP_ENTRY_CMD: next_dpd = !operation_in_progress_bit;
					IDENTIFICATION_READ_CMD: begin
						if (!operation_in_progress_bit) begin
							next_phase = PH_DATA_OUT;
						end
					end
					QUAD_IDENTIFICATION_READ_CMD: begin
						if (!operation_in_progress_bit && quad) begin
							next_phase = PH_DATA_OUT;
						end
					end
					PARAMETER_TABLE_READ_CMD: next_phase = PH_ADDR;
					default: ;
				endcase
			end
		end else if (byte_done && phase == PH_ADDR) begin
			next_addr = {addr[15:0], nb};
			next_abytes = abytes + 2'h1;
			if (abytes == 2'h2) begin
				next_dcnt = 3'h0;
				if (opcode == PARAMETER_TABLE_READ_CMD) begin
					next_phase = PH_DUMMY;
				end else if (opcode == PAGE_PROGRAM_CMD) begin
					next_phase = PH_DATA_IN;
					next_op_ok = 1'b1;
				end else begin
					next_phase = PH_IGNORE;
					next_op_ok = 1'b1;
				end
			end
		end else if (byte_done && phase == PH_DATA_IN) begin
			prog_we = 1'b1;
			next_mem[addr[MEM_AW-1:0]] = mem[addr[MEM_AW-1:0]] & nb;
			next_addr = page_next(addr, config2[PAGE512_BIT]);
			next_got_data = 1'b1;
		end else if (rise && phase == PH_DUMMY) begin
			next_dcnt = dcnt + 3'h1;
			if (dcnt == DUMMY_LAST) begin
				next_phase = PH_DATA_OUT;
				next_optr = addr;
			end
		end else if (fall && phase == PH_DATA_OUT) begin
			if (tx_left == 3'h0) begin
				ob = (opcode == PARAMETER_TABLE_READ_CMD) ? sfdp_byte(optr) : id_byte(optr);
				next_optr = optr + 24'h000001;
				next_tx_left = quad ? 3'h1 : 3'h7;
			end else begin
				next_tx_left = tx_left - 3'h1;
			end
			// Output only moves on falling edges so the host samples on the next rise
			if (quad) begin
				next_io_out = ob[7:4];
				next_tx = {ob[3:0], 4'h0};
				next_io_oe = 4'hF;
			end else begin
				next_io_out = {2'h0, ob[7], 1'b0};
				next_tx = {ob[6:0], 1'b0};
				next_io_oe = 4'h2;
			end
		end
		if (sw_reset) begin
			next_wel = 1'b0;
			next_wip = 1'b0;
			next_busy = 12'h000;
			next_dpd = 1'b0;
			next_rel_pend = 1'b0;
			next_cont = 1'b0;
			next_config2 = CONFIG_RST;
			next_armed = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			sck_q <= 1'b0;
			cs_q <= 1'b1;
			phase <= PH_OPCODE;
			opcode <= 8'h00;
			shreg <= 8'h00;
			bitcnt <= 4'h0;
			abytes <= 2'h0;
			dcnt <= 3'h0;
			tx <= 8'h00;
			tx_left <= 3'h0;
			addr <= 24'h000000;
			optr <= 24'h000000;
			for (int i = 0; i < MEM_BYTES; i++) begin
				mem[i] <= 8'hFF;
			end
			{operation_in_progress_bit, wel, deep_sleep_entry_cmd, rel_pend, cont, armed, op_ok, got_data} <= 8'h00;
			busy <= 12'h000;
			rel_cnt <= 12'h000;
			config2 <= CONFIG_RST;
			locks <= LOCK_RST;
			io_out <= 4'h0;
			io_oe <= 4'h0;
		end else begin
			sck_q <= pins_s.sck;
			cs_q <= pins_s.cs_b;
			phase <= next_phase;
			opcode <= next_opcode;
			shreg <= next_shreg;
			bitcnt <= next_bitcnt;
			abytes <= next_abytes;
			dcnt <= next_dcnt;
			tx <= next_tx;
			tx_left <= next_tx_left;
			addr <= next_addr;
			optr <= next_optr;
			mem <= next_mem;
			{operation_in_progress_bit, wel, deep_sleep_entry_cmd, rel_pend, cont, armed, op_ok, got_data} <=
				{next_wip, next_wel, next_dpd, next_rel_pend, next_cont, next_armed, next_op_ok, next_got_data};
			busy <= next_busy;
			rel_cnt <= next_rel_cnt;
			config2 <= next_config2;
			locks <= next_locks;
			io_out <= next_io_out;
			io_oe <= next_io_oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence s_id_cmd;
		op_fire && nb == IDENTIFICATION_READ_CMD && !deep_sleep_entry_cmd && !cont && !operation_in_progress_bit;
	endsequence

	sequence s_id_drive;
		##[1:40] (io_oe != 4'h0 || pins_s.cs_b);
	endsequence

	a_prog_clears_only: assert property (prog_we |=> mem[$past(addr[MEM_AW-1:0])] == ($past(mem[addr[MEM_AW-1:0]]) & $past(nb)))
		else $error("program set a bit");
	a_prog_needs_wel: assert property (prog_we |-> !operation_in_progress_bit && wel && opcode == PAGE_PROGRAM_CMD && op_ok)
		else $error("program without write enable");
	a_erase_all_ones: assert property (erase_fire |=> mem[{$past(addr[MEM_AW-1:SECTOR_AW]), 4'h0}] == 8'hFF && operation_in_progress_bit && !wel)
		else $error("erase left a zero");
	a_reset_keeps_locks: assert property (sw_reset |=> locks == $past(locks) && !wel && !operation_in_progress_bit && !deep_sleep_entry_cmd && config2 == CONFIG_RST)
		else $error("software reset wrong");
	a_cont_exit: assert property (op_fire && cont && !deep_sleep_entry_cmd && nb == MODE_BIT_RESET_CMD |=> !cont)
		else $error("continuous mode not left");
	a_dpd_when_idle: assert property ($rose(deep_sleep_entry_cmd) |-> $past(!operation_in_progress_bit && op_fire))
		else $error("deep sleep entered while busy");
	a_dpd_ignores: assert property (deep_sleep_entry_cmd && op_fire && nb != DEEP_SLEEP_RELEASE_CMD |=> deep_sleep_entry_cmd && phase == PH_IGNORE)
		else $error("command heard in deep sleep");
	a_release_delay: assert property ($rose(rel_pend) |-> deep_sleep_entry_cmd throughout (rel_pend [*8]))
		else $error("release too early");
	// The busy counter must keep counting down at its normal pace
	a_id_busy_ignored: assert property (op_fire && nb == IDENTIFICATION_READ_CMD && operation_in_progress_bit |=> phase == PH_IGNORE && busy == $past(busy) - 12'h001)
		else $error("id read disturbed operation");
	a_id_first_out: assert property (s_id_cmd |-> s_id_drive)
		else $error("id data not driven");
	a_quad_id_gate: assert property (op_fire && nb == QUAD_IDENTIFICATION_READ_CMD && !quad |=> phase != PH_DATA_OUT)
		else $error("quad id heard outside quad mode");
	a_dummy_count: assert property (phase == PH_DUMMY && rise && dcnt == DUMMY_LAST |=> phase == PH_DATA_OUT && optr == $past(addr))
		else $error("dummy count wrong");

endmodule : fcl_flash_cmd
`default_nettype wire

/* bench/fcl_host.sv */
`timescale 1ns/1ps
`default_nettype none
// SPI host in mode 0; link clock stands low between frames
module fcl_host (
	output logic cs_b,
	output logic sck,
	output logic [3:0] io_drive,
	input wire logic [3:0] io_line,
	input wire logic [3:0] io_oe
);
	initial begin
		cs_b = 1'b1;
		sck = 1'b0;
		io_drive = 4'h5;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One frame: nout bits sent MSb first, then nin bits taken back
	task frame(input int nout, input logic [63:0] txd, input int nin, input logic q,
		output logic [63:0] rxd, output logic oe);
		int w;
		int i;
		w = q ? 4 : 1;
		rxd = 64'h0;
		oe = 1'b0;
		#37.3 cs_b = 1'b0;
		for (i = 0; i < (nout + nin) / w; i++) begin
			// Idle lines toggle so a line nobody drives never looks like data
			io_drive = ~io_drive;
			if (i * w < nout && q)
				io_drive = txd[63 - i * 4 -: 4];
			else if (i * w < nout)
				io_drive[0] = txd[63 - i];
			#100 sck = 1'b1;
			#99 oe = oe | (|io_oe);
			if (i * w >= nout)
				rxd = q ? {rxd[59:0], io_line} : {rxd[62:0], io_line[1]};
			#1 sck = 1'b0;
		end
		// Host may stop output at any byte by raising select
		#100 cs_b = 1'b1;
		#250;
	endtask : frame
endmodule : fcl_host
`default_nettype wire

/* bench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import fcl_pkg::*;
	localparam logic [63:0] ID_ALL = {ID_MFR, ID_DEV0, ID_DEV1, ID_EXT, 32'h515259FF};
	localparam logic [55:0] SFDP_TAB = 56'h534644500601FF;
	localparam logic [31:0] RES_OPS = 32'h75B07A8A;
	localparam logic [31:0] ER_OPS = {PARAM_ERASE_CMD, SECTOR_ERASE_CMD, BULK_ERASE_CMD, BULK_ERASE_ALT_CMD};
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	wire logic hreadyout;
	wire logic hresp;
	wire logic [31:0] hrdata;
	wire logic cs_b;
	wire logic sck;
	wire logic [3:0] host_io;
	wire logic [3:0] io_out;
	wire logic [3:0] io_oe;
	wire logic [3:0] line;
	int bad_count = 0;
	int samples_checked = 0;
	int seed = 73;
	int i;
	logic [31:0] rv;
	logic [63:0] rx;
	logic oe;
	logic [23:0] a;
	logic [7:0] d;

	always #12.5 core_clk = ~core_clk;
	assign line = (io_oe & io_out) | (~io_oe & host_io);

	fcl_flash_cmd fcl_flash_cmd_inst (.core_clk(core_clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck),
		.io_in(line), .io_out(io_out), .io_oe(io_oe), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata));
	fcl_host fcl_host_inst (.cs_b(cs_b), .sck(sck), .io_drive(host_io), .io_line(line), .io_oe(io_oe));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] sfdp(input logic [23:0] x);
		return (x < 7) ? SFDP_TAB[55 - x * 8 -: 8] : 8'hFF;
	endfunction : sfdp

	task print_verdict;
		$display("Mismatches %0d, compares %0d", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	task check(input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task timeout;
		bad_count++;
		$display("[FAIL] %0t wait ran out", $time);
		print_verdict;
	endtask : timeout

	// Single word transfer; the wait for ready is bounded, never assumed
	task ahb(input logic w, input logic [31:0] ad, input logic [31:0] wd);
		int n;
		@(posedge core_clk);
		haddr <= ad;
		hwrite <= w;
		htrans <= 2'h2;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 40);
		rv = hrdata;
		if (n >= 40)
			timeout;
		check(hresp, 1'b0);
	endtask : ahb

	task reg_is(input logic [7:0] ad, input logic [31:0] e);
		ahb(1'b0, {24'h0, ad}, 32'h0);
		check(rv, e);
	endtask : reg_is

	task cmd(input logic [7:0] op, input int n);
		fcl_host_inst.frame(n, {op, 56'h0}, 16, 1'b0, rx, oe);
	endtask : cmd

	task wait_idle;
		int n;
		n = 0;
		do begin
			ahb(1'b0, 32'h0, 32'h0);
			n++;
		end while (rv[0] !== 1'b0 && n < 2000);
		if (n >= 2000)
			timeout;
	endtask : wait_idle

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		// Every flop resets synchronously, so two edges of reset suffice
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge core_clk);
		for (i = 0; i < 4; i++)
			reg_is(8'(i * 4), 32'h0);
		ahb(1'b1, 32'h100, 32'hFF);
		ahb(1'b1, 32'h0, 32'h3);
		reg_is(REG_STATUS_OFS, 32'h0);
		ahb(1'b0, 32'h100, 32'h0);
		check(rv, 32'h0);
		for (i = 0; i < 2; i++) begin
			fcl_host_inst.frame(8, {IDENTIFICATION_READ_CMD, 56'h0}, i ? 64 : 16, 1'b0, rx, oe);
			check(rx, i ? ID_ALL : ID_ALL >> 48);
		end
		repeat (3) begin
			a = 24'(($random(seed) & 32'h7) % 7);
			fcl_host_inst.frame(40, {PARAMETER_TABLE_READ_CMD, a, 32'h0}, 16, 1'b0, rx, oe);
			check(rx, {48'h0, sfdp(a), sfdp(a + 1)});
		end
		d = 8'($random(seed));
		fcl_host_inst.frame(40, {PAGE_PROGRAM_CMD, 24'h0, d, 24'h0}, 0, 1'b0, rx, oe);
		reg_is(REG_STATUS_OFS, 32'h0);
		cmd(WRITE_ENABLE_CMD, 8);
		reg_is(REG_STATUS_OFS, 32'h2);
		// Address only, no trailing clocks: no data byte may reach the array
		fcl_host_inst.frame(32, {PAGE_PROGRAM_CMD, 56'h0}, 0, 1'b0, rx, oe);
		ahb(1'b0, 32'h0, 32'h0);
		check(rv[0], 1'b0);
		fcl_host_inst.frame(48, {PAGE_PROGRAM_CMD, 24'h0, d, ~d, 16'h0}, 0, 1'b0, rx, oe);
		reg_is(REG_STATUS_OFS, 32'h1);
		cmd(IDENTIFICATION_READ_CMD, 8);
		check(oe, 1'b0);
		cmd(DEEP_SLEEP_ENTRY_CMD, 8);
		reg_is(REG_STATE_OFS, 32'h0);
		wait_idle;
		cmd(SECTOR_ERASE_CMD, 32);
		reg_is(REG_STATUS_OFS, 32'h0);
		for (i = 0; i < 4; i++) begin
			cmd(WRITE_ENABLE_CMD, 8);
			cmd(ER_OPS[31 - i * 8 -: 8], i < 2 ? 32 : 8);
			reg_is(REG_STATUS_OFS, 32'h1);
			wait_idle;
		end
		cmd(DEEP_SLEEP_ENTRY_CMD, 8);
		reg_is(REG_STATE_OFS, 32'h1);
		cmd(IDENTIFICATION_READ_CMD, 8);
		check(oe, 1'b0);
		cmd(WRITE_ENABLE_CMD, 8);
		reg_is(REG_STATUS_OFS, 32'h0);
		// Short frame so the release delay is still running when we look
		fcl_host_inst.frame(8, {DEEP_SLEEP_RELEASE_CMD, 56'h0}, 0, 1'b0, rx, oe);
		reg_is(REG_STATE_OFS, 32'h5);
		repeat (REL_CYC) @(posedge core_clk);
		reg_is(REG_STATE_OFS, 32'h0);
		ahb(1'b1, 32'h0C, 32'h2);
		reg_is(REG_STATE_OFS, 32'h2);
		cmd(IDENTIFICATION_READ_CMD, 8);
		check(oe, 1'b0);
		cmd(MODE_BIT_RESET_CMD, 8);
		reg_is(REG_STATE_OFS, 32'h0);
		repeat (3) begin
			cmd(RES_OPS[31 - ($random(seed) & 32'h3) * 8 -: 8], 8);
			check(oe, 1'b0);
			reg_is(REG_STATUS_OFS, 32'h0);
			reg_is(REG_STATE_OFS, 32'h0);
		end
		for (i = 0; i < 2; i++) begin
			// Page size bit only; quad mode would garble the serial commands below
			ahb(1'b1, 32'h04, 32'h10);
			ahb(1'b1, 32'h08, 32'h3);
			cmd(WRITE_ENABLE_CMD, 8);
			if (i == 0)
				cmd(RESET_ENABLE_CMD, 8);
			cmd(i ? LEGACY_RESET_CMD : RESET_CMD, 8);
			reg_is(REG_CONFIG_OFS, 32'h0);
			reg_is(REG_STATUS_OFS, 32'h0);
			reg_is(REG_LOCK_OFS, 32'h3);
		end
		cmd(QUAD_IDENTIFICATION_READ_CMD, 8);
		check(oe, 1'b0);
		ahb(1'b1, 32'h04, 32'h40);
		fcl_host_inst.frame(8, {IDENTIFICATION_READ_CMD, 56'h0}, 64, 1'b1, rx, oe);
		check(rx, ID_ALL);
		fcl_host_inst.frame(8, {QUAD_IDENTIFICATION_READ_CMD, 56'h0}, 64, 1'b1, rx, oe);
		check(rx, ID_ALL);
		fcl_host_inst.frame(64, {PARAMETER_TABLE_READ_CMD, 24'h2, 32'h0}, 16, 1'b1, rx, oe);
		check(rx, {48'h0, sfdp(24'h2), sfdp(24'h3)});
		print_verdict;
	end
endmodule : testbench
`default_nettype wire
